/* tvcs_pkg.sv */
// Package of register offsets, field positions and reset values for the control and status bank.
package tvcs_pkg;
    localparam logic [15:0] OFS_GENERAL_CONTROL = 16'h1000;
    localparam logic [15:0] OFS_MODULE_STATUS = 16'h1002;
    localparam logic [15:0] OFS_RELOC_HIGH = 16'h1004;
    localparam logic [15:0] OFS_RELOC_MID = 16'h1006;
    localparam logic [15:0] OFS_RELOC_SELECT = 16'h1008;
    localparam logic [15:0] OFS_INT_LEVEL = 16'h100A;
    localparam logic [15:0] OFS_INT_VECTOR = 16'h100C;
    localparam logic [15:0] OFS_SLOT_ID = 16'h100E;
    localparam logic [15:0] OFS_BCAST_BASE = 16'h1010;
    localparam logic [15:0] OFS_CHAIN_CTRL = 16'h1012;
    localparam logic [15:0] OFS_MODULE_RESET = 16'h1014;
    localparam logic [15:0] OFS_TEST_WORD = 16'h1028;
    localparam logic [15:0] OFS_ALMOST_FULL = 16'h1022;
    // Control register field positions.
    localparam int CTL_BUS_ERROR_ENABLE = 0;
    localparam int CTL_TERM = 1;
    localparam int CTL_TERMINATION_SOURCE_SELECT = 2;
    localparam int CTL_EMPTY_EVENT = 3;
    localparam int CTL_ALIGN_PAD = 4;
    localparam int CTL_COMP_EN = 5;
    localparam int CTL_TEST_BUF = 6;
    localparam int CTL_SRAM_READ = 7;
    localparam int CTL_EVQ_EN = 8;
    localparam int CTL_TTAG_EN = 9;
    localparam logic [15:0] CTL_RESET = 16'h0020;
    // Status register field positions.
    localparam int ST_HAS_DATA = 0;
    localparam int ST_ALMOST_FULL = 1;
    localparam int ST_FULL = 2;
    localparam int ST_MATCH = 3;
    localparam int ST_HEADER_EN = 4;
    localparam int ST_TERM_ON = 5;
    localparam int ST_ERR0 = 6;
    localparam int ST_BERR_SEEN = 11;
    localparam int ST_DRAINED = 12;
    localparam int ST_RES0 = 13;
    localparam int ST_PAIR = 15;
    localparam int ST_TRG_LOST = 10;
    // Reset values and sizes.
    localparam logic [2:0] INT_LEVEL_RESET = 3'h0;
    localparam logic [7:0] INT_VECTOR_RESET = 8'hDD;
    localparam logic [4:0] SLOT_ID_RESET = 5'h1F;
    localparam logic [7:0] BCAST_BASE_RESET = 8'hAA;
    localparam logic [15:0] ALMOST_FULL_RESET = 16'h0040;
    localparam logic [15:0] BUF_CAPACITY = 16'h8000;
    localparam logic [15:0] FULL_MARGIN = 16'h0021;
    localparam logic [15:0] FULL_LEVEL = BUF_CAPACITY - FULL_MARGIN;
    localparam logic [4:0] FILLER_TAG = 5'h18;

    // One register access from the bus slave.
    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic block;
        logic chained;
    } tvcs_acc_t;

    // Event description from the acquisition side.
    typedef struct packed {
        logic done;
        logic [15:0] count;
        logic [15:0] words;
        logic has_hits;
    } tvcs_event_t;
endpackage

/* tvcs_regs.sv */
// Control and status register bank of the multihit converter module.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Bus error enable clear answers acknowledge; set ends blocks or empty reads with bus error.
// - Termination follows switch or software bit by source select; status shows actual state.
// - Empty events write nothing unless empty-event bit set, then header and trailer.
// - Padding bit appends one invalid filler to odd-length events in block readout.
// - Compensation enable bit drives nonlinearity compensation; resets to one.
// - Buffer test mode loads test register words to buffer, blocks chip data.
// - Correction table readback allowed only when its bit is one; resets zero.
// - Event queue enabled pushes counter and word count word per written event.
// - Time tag enable bit controls tag word per event; disabled at reset.
// - Data-present flag: complete event in matching mode, any data in continuous.
// - Almost-full flag set when buffer count reaches programmed level.
// - Full flag set at capacity minus thirty-three words.
// - Status shows operating mode, chip header enable and pulse pair mode.
// - Resolution code encodes 800, 200 or 100 picoseconds as 00, 01, 10.
// - One sticky error bit per converter chip, four chips here.
// - Bus-error-seen flag sets on issued bus error, clears after status read.
// - Drained flag set when empty or chain sent; held until chain ends.
// - Trigger-dropped flag sets on lost trigger, clears after status read.
// - Two byte relocation registers hold address bits 31..24 and 23..16.
// - Relocation select chooses switch or register base; slot identifier unaffected.
// - Interrupt level in low three bits, resets zero, zero disables interrupts.
// - Acknowledge cycle drives low vector byte; resets to DD hex.
// - Slot identifier five bits, resets all ones, placed in global header and trailer.
// - Broadcast base resets AA hex; any module reset access gives one reset pulse.
module tvcs_regs
    import tvcs_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Register access.
    input wire tvcs_acc_t acc,
    input wire logic iack,
    output logic ack,
    output logic berr,
    output logic [31:0] rdata,
    // Board straps and acquisition state.
    input wire logic [7:0] switch_base,
    input wire logic switch_term,
    input wire logic [15:0] buf_words,
    input wire logic [15:0] buf_events,
    input wire logic matching_mode_flag,
    input wire logic chip_header_en,
    input wire logic pair_mode,
    input wire logic [1:0] resolution_code,
    input wire logic [3:0] chip_error,
    input wire logic trigger_dropped,
    input wire logic chain_done,
    input wire tvcs_event_t event_in,
    input wire logic [31:0] chip_word,
    input wire logic chip_word_valid,
    // Controls toward the acquisition.
    output logic termination_on,
    output logic write_empty_header,
    output logic pad_odd_event,
    output logic compensation_on,
    output logic correction_read_en,
    output logic timestamp_on,
    output logic [31:0] buf_word,
    output logic buf_word_valid,
    output logic [31:0] evq_word,
    output logic evq_push,
    output logic [15:0] active_base,
    output logic [4:0] slot_identifier,
    output logic [7:0] bcast_base,
    output logic [15:0] chain_ctrl,
    output logic [2:0] irq_level,
    output logic irq_enabled,
    output logic module_reset_pulse
);

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] control_reg;
    logic [15:0] status_reg;
    logic [7:0] reloc_high_reg;
    logic [7:0] reloc_mid_reg;
    logic reloc_sel_reg;
    logic [2:0] int_level_reg;
    logic [7:0] int_vector_reg;
    logic [4:0] slot_id_reg;
    logic [7:0] bcast_reg;
    logic [15:0] chain_reg;
    logic [15:0] almost_full_reg;
    logic [3:0] chip_err_reg;
    logic berr_seen_reg;
    logic trg_lost_reg;
    logic chain_active_reg;
    logic wr_hit;
    logic rd_status;
    logic empty_read;
    logic raise_berr;
    logic [15:0] status_next;

    // Decode of an access to one offset.
    function automatic logic hit(input tvcs_acc_t a, input logic [15:0] ofs);
        hit = a.req && (a.addr == ofs);
    endfunction

    assign wr_hit = acc.req && acc.wr;
    assign rd_status = hit(acc, OFS_MODULE_STATUS) && !acc.wr;
    assign empty_read = acc.req && !acc.wr && (acc.addr < OFS_GENERAL_CONTROL) && (buf_words == 16'h0000);
    // Reads that run into an empty buffer or finish a block end with bus error only when enabled.
    assign raise_berr = control_reg[CTL_BUS_ERROR_ENABLE] && (empty_read || (acc.block && acc.req && chain_done));

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (srst) begin
            control_reg <= CTL_RESET;
        end else if (wr_hit && hit(acc, OFS_GENERAL_CONTROL)) begin
            control_reg <= {6'h00, acc.wdata[9:0]};
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reloc_high_reg <= 8'h00;
            reloc_mid_reg <= 8'h00;
            reloc_sel_reg <= 1'b0;
        end else if (wr_hit) begin
            if (hit(acc, OFS_RELOC_HIGH)) begin
                reloc_high_reg <= acc.wdata[7:0];
            end
            if (hit(acc, OFS_RELOC_MID)) begin
                reloc_mid_reg <= acc.wdata[7:0];
            end
            if (hit(acc, OFS_RELOC_SELECT)) begin
                reloc_sel_reg <= acc.wdata[0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            int_level_reg <= INT_LEVEL_RESET;
            int_vector_reg <= INT_VECTOR_RESET;
            slot_id_reg <= SLOT_ID_RESET;
            bcast_reg <= BCAST_BASE_RESET;
            chain_reg <= 16'h0000;
            almost_full_reg <= ALMOST_FULL_RESET;
        end else if (wr_hit) begin
            if (hit(acc, OFS_INT_LEVEL)) begin
                int_level_reg <= acc.wdata[2:0];
            end
            if (hit(acc, OFS_INT_VECTOR)) begin
                int_vector_reg <= acc.wdata[7:0];
            end
            if (hit(acc, OFS_SLOT_ID)) begin
                slot_id_reg <= acc.wdata[4:0];
            end
            if (hit(acc, OFS_BCAST_BASE)) begin
                bcast_reg <= acc.wdata[7:0];
            end
            if (hit(acc, OFS_CHAIN_CTRL)) begin
                chain_reg <= acc.wdata[15:0];
            end
            if (hit(acc, OFS_ALMOST_FULL)) begin
                almost_full_reg <= acc.wdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags: a new event in the read cycle wins over the clear.
    always_ff @(posedge clock) begin
        if (srst) begin
            berr_seen_reg <= 1'b0;
            trg_lost_reg <= 1'b0;
            chip_err_reg <= 4'h0;
        end else begin
            berr_seen_reg <= raise_berr || (berr_seen_reg && !rd_status);
            trg_lost_reg <= trigger_dropped || (trg_lost_reg && !rd_status);
            chip_err_reg <= chip_err_reg | chip_error;
        end
    end

    // A chained transfer keeps the drained flag up from its final access until chained drops.
    always_ff @(posedge clock) begin
        if (srst) begin
            chain_active_reg <= 1'b0;
        end else if (acc.req && acc.chained && chain_done) begin
            chain_active_reg <= 1'b1;
        end else if (!acc.chained) begin
            chain_active_reg <= 1'b0;
        end
    end

    always_comb begin
        status_next = 16'h0000;
        status_next[ST_HAS_DATA] = matching_mode_flag ? (buf_events != 16'h0000) : (buf_words != 16'h0000);
        status_next[ST_ALMOST_FULL] = buf_words >= almost_full_reg;
        status_next[ST_FULL] = buf_words >= FULL_LEVEL;
        status_next[ST_MATCH] = matching_mode_flag;
        status_next[ST_HEADER_EN] = chip_header_en;
        status_next[ST_TERM_ON] = control_reg[CTL_TERMINATION_SOURCE_SELECT] ? control_reg[CTL_TERM] : switch_term;
        status_next[ST_ERR0 +: 4] = chip_err_reg;
        status_next[ST_TRG_LOST] = trg_lost_reg;
        status_next[ST_BERR_SEEN] = berr_seen_reg;
        status_next[ST_DRAINED] = (buf_words == 16'h0000) || chain_active_reg;
        status_next[ST_RES0 +: 2] = resolution_code;
        status_next[ST_PAIR] = pair_mode;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            status_reg <= 16'h0000;
        end else begin
            status_reg <= status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read answer; unmapped locations read zero and ignore writes, write-only locations read zero.
    always_ff @(posedge clock) begin
        if (srst) begin
            ack <= 1'b0;
            berr <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ack <= (acc.req || iack) && !raise_berr;
            berr <= raise_berr;
            rdata <= 32'h0000_0000;
            if (iack) begin
                rdata <= {24'h000000, int_vector_reg};
            end else if (acc.req && !acc.wr) begin
                unique case (acc.addr)
                    OFS_GENERAL_CONTROL: rdata <= {16'h0000, control_reg};
                    OFS_MODULE_STATUS: rdata <= {16'h0000, status_reg};
                    OFS_RELOC_HIGH: rdata <= {24'h000000, reloc_high_reg};
                    OFS_RELOC_MID: rdata <= {24'h000000, reloc_mid_reg};
                    OFS_INT_LEVEL: rdata <= {29'h00000000, int_level_reg};
                    OFS_INT_VECTOR: rdata <= {24'h000000, int_vector_reg};
                    OFS_SLOT_ID: rdata <= {27'h0000000, slot_id_reg};
                    OFS_BCAST_BASE: rdata <= {24'h000000, bcast_reg};
                    OFS_CHAIN_CTRL: rdata <= {16'h0000, chain_reg};
                    OFS_ALMOST_FULL: rdata <= {16'h0000, almost_full_reg};
                    default: rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output buffer feed: test words replace chip data while test mode is on.
    always_ff @(posedge clock) begin
        if (srst) begin
            buf_word <= 32'h0000_0000;
            buf_word_valid <= 1'b0;
        end else if (control_reg[CTL_TEST_BUF]) begin
            buf_word <= acc.wdata;
            buf_word_valid <= wr_hit && hit(acc, OFS_TEST_WORD);
        end else begin
            buf_word <= chip_word;
            buf_word_valid <= chip_word_valid;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            evq_word <= 32'h0000_0000;
            evq_push <= 1'b0;
        end else begin
            evq_word <= {event_in.count, event_in.words};
            evq_push <= control_reg[CTL_EVQ_EN] && event_in.done && (event_in.has_hits || control_reg[CTL_EMPTY_EVENT]);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            termination_on <= 1'b0;
            write_empty_header <= 1'b0;
            pad_odd_event <= 1'b0;
            compensation_on <= 1'b1;
            correction_read_en <= 1'b0;
            timestamp_on <= 1'b0;
            active_base <= 16'h0000;
            slot_identifier <= SLOT_ID_RESET;
            bcast_base <= BCAST_BASE_RESET;
            chain_ctrl <= 16'h0000;
            irq_level <= INT_LEVEL_RESET;
            irq_enabled <= 1'b0;
            module_reset_pulse <= 1'b0;
        end else begin
            termination_on <= status_next[ST_TERM_ON];
            write_empty_header <= control_reg[CTL_EMPTY_EVENT];
            pad_odd_event <= control_reg[CTL_ALIGN_PAD];
            compensation_on <= control_reg[CTL_COMP_EN];
            correction_read_en <= control_reg[CTL_SRAM_READ];
            timestamp_on <= control_reg[CTL_TTAG_EN];
            // The old base stops answering one cycle after relocation is selected.
            active_base <= reloc_sel_reg ? {reloc_high_reg, reloc_mid_reg} : {8'h00, switch_base};
            slot_identifier <= slot_id_reg;
            bcast_base <= bcast_reg;
            chain_ctrl <= chain_reg;
            irq_level <= int_level_reg;
            irq_enabled <= int_level_reg != INT_LEVEL_RESET;
            module_reset_pulse <= hit(acc, OFS_MODULE_RESET);
        end
    end

endmodule

/* tvcs_checker.sv */
// Concurrent checks on the ports of the control and status bank.
`timescale 1ns/1ps
module tvcs_checker
    import tvcs_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Register access.
    input wire tvcs_acc_t acc,
    input wire logic iack,
    input wire logic ack,
    input wire logic berr,
    input wire logic [31:0] rdata,
    // Controls.
    input wire logic switch_term,
    input wire logic termination_on,
    input wire logic write_empty_header,
    input wire logic pad_odd_event,
    input wire logic compensation_on,
    input wire logic correction_read_en,
    input wire logic timestamp_on,
    input wire logic [31:0] buf_word,
    input wire logic buf_word_valid,
    input wire logic [2:0] irq_level,
    input wire logic irq_enabled,
    input wire logic module_reset_pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////
    // Control outputs are compared only once a control write has settled, so latency is not pinned.
    logic [15:0] ctl_reg;
    logic [1:0] age_reg;
    always_ff @(posedge clock) begin
        if (srst) begin
            ctl_reg <= CTL_RESET;
            age_reg <= 2'h3;
        end else if (acc.req && acc.wr && acc.addr == OFS_GENERAL_CONTROL) begin
            ctl_reg <= acc.wdata[15:0];
            age_reg <= 2'h0;
        end else if (age_reg != 2'h3) begin
            age_reg <= age_reg + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    property p_answer; acc.req |=> ack != berr; endproperty
    a_answer: assert property (p_answer) else $error("access not answered once");
    property p_berr; berr |-> $past(ctl_reg[CTL_BUS_ERROR_ENABLE]) && $past(acc.req) && $past(acc.addr) < 16'h1000;
    endproperty
    a_berr: assert property (p_berr) else $error("bus error on a register access");
    property p_term; age_reg == 2'h3 && $stable(switch_term) && $past(switch_term) == $past(switch_term, 2)
        |-> termination_on == (ctl_reg[CTL_TERMINATION_SOURCE_SELECT] ? ctl_reg[CTL_TERM] : switch_term); endproperty
    a_term: assert property (p_term) else $error("termination source wrong");
    property p_empty; age_reg == 2'h3 |-> write_empty_header == ctl_reg[CTL_EMPTY_EVENT]; endproperty
    a_empty: assert property (p_empty) else $error("empty event control wrong");
    property p_pad; age_reg == 2'h3 |-> pad_odd_event == ctl_reg[CTL_ALIGN_PAD]; endproperty
    a_pad: assert property (p_pad) else $error("padding control wrong");
    property p_comp; age_reg == 2'h3 |-> compensation_on == ctl_reg[CTL_COMP_EN]; endproperty
    a_comp: assert property (p_comp) else $error("compensation control wrong");
    property p_sram; age_reg == 2'h3 |-> correction_read_en == ctl_reg[CTL_SRAM_READ]; endproperty
    a_sram: assert property (p_sram) else $error("table readback control wrong");
    property p_ttag; age_reg == 2'h3 |-> timestamp_on == ctl_reg[CTL_TTAG_EN]; endproperty
    a_ttag: assert property (p_ttag) else $error("time tag control wrong");
    property p_test; age_reg == 2'h3 && ctl_reg[CTL_TEST_BUF] && acc.req && acc.wr && acc.addr == OFS_TEST_WORD
        |=> buf_word_valid && buf_word == $past(acc.wdata); endproperty
    a_test: assert property (p_test) else $error("test word not loaded");
    property p_irq; irq_enabled == (irq_level != 3'h0); endproperty
    a_irq: assert property (p_irq) else $error("interrupt enable wrong");
    property p_iack; iack |=> ack && rdata[31:8] == 24'h0; endproperty
    a_iack: assert property (p_iack) else $error("acknowledge cycle answer wrong");
    property p_mreset; acc.req && acc.addr == OFS_MODULE_RESET |=> module_reset_pulse ##1 !module_reset_pulse;
    endproperty
    a_mreset: assert property (p_mreset) else $error("module reset pulse wrong");
endmodule
bind tvcs_regs tvcs_checker u_chk (.clock, .srst, .acc, .iack, .ack, .berr, .rdata, .switch_term,
    .termination_on, .write_empty_header, .pad_odd_event, .compensation_on, .correction_read_en,
    .timestamp_on, .buf_word, .buf_word_valid, .irq_level, .irq_enabled, .module_reset_pulse);

/* tvcs_master.sv */
// Bus master model issuing single register and acknowledge cycles.
`timescale 1ns/1ps
module tvcs_master
    import tvcs_pkg::*;
(
    // Clock.
    input wire logic clock,
    // Request.
    output tvcs_acc_t acc,
    output logic iack,
    // Answer.
    input wire logic ack,
    input wire logic berr,
    input wire logic [31:0] rdata
);
    initial begin
        acc = '0;
        iack = 1'b0;
    end
    // Released address and data lines show inverted values, so a stale address is never read as a held one.
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic ia,
                        output logic [31:0] rd, output logic [1:0] resp);
        @(posedge clock);
        acc.req <= ~ia;
        acc.wr <= wr;
        acc.addr <= a;
        acc.wdata <= d;
        iack <= ia;
        @(posedge clock);
        acc.req <= 1'b0;
        acc.addr <= ~a;
        acc.wdata <= ~d;
        iack <= 1'b0;
        @(posedge clock);
        rd = rdata;
        resp = {ack, berr};
    endtask
    task automatic mode(input logic b, input logic c);
        @(posedge clock);
        acc.block <= b;
        acc.chained <= c;
    endtask
endmodule

/* tvcs_regs_tb.sv */
// Self-checking bench of the control and status bank.
`timescale 1ns/1ps
module tvcs_regs_tb;
    import tvcs_pkg::*;
    logic clock, srst, iack, ack, berr, switch_term, matching_mode_flag, chip_header_en, pair_mode;
    logic trigger_dropped, chain_done, chip_word_valid, termination_on, write_empty_header, pad_odd_event;
    logic compensation_on, correction_read_en, timestamp_on, buf_word_valid, evq_push, irq_enabled;
    logic module_reset_pulse;
    tvcs_acc_t acc;
    tvcs_event_t event_in;
    logic [31:0] rdata, buf_word, evq_word, chip_word, rd;
    logic [15:0] buf_words, buf_events, active_base, chain_ctrl;
    logic [7:0] switch_base, bcast_base;
    logic [4:0] slot_identifier;
    logic [3:0] chip_error;
    logic [2:0] irq_level;
    logic [1:0] resolution_code, resp;
    logic [15:0] lv [5] = '{16'h0000, 16'h003F, 16'h0040, FULL_LEVEL - 16'h0001, FULL_LEVEL};
    int errors, num_checks;
    tvcs_regs uut (.clock, .srst, .acc, .iack, .ack, .berr, .rdata, .switch_base, .switch_term, .buf_words,
        .buf_events, .matching_mode_flag, .chip_header_en, .pair_mode, .resolution_code, .chip_error,
        .trigger_dropped, .chain_done, .event_in, .chip_word, .chip_word_valid, .termination_on,
        .write_empty_header, .pad_odd_event, .compensation_on, .correction_read_en, .timestamp_on, .buf_word,
        .buf_word_valid, .evq_word, .evq_push, .active_base, .slot_identifier, .bcast_base, .chain_ctrl,
        .irq_level, .irq_enabled, .module_reset_pulse);
    tvcs_master m (.clock, .acc, .iack, .ack, .berr, .rdata);
    ////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        m.xfer(1'b1, a, d, 1'b0, rd, resp);
    endtask
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
        m.xfer(1'b0, a, 32'h0, 1'b0, rd, resp);
        check({what, " answer"}, {30'h0, resp}, 32'h2);
        check(what, rd, exp);
    endtask
    function automatic logic [31:0] stat(input logic trg, input logic bs, input logic term, input logic [3:0] err);
        logic hd;
        hd = matching_mode_flag ? (buf_events != 16'h0) : (buf_words != 16'h0);
        return {16'h0, pair_mode, resolution_code, buf_words == 16'h0, bs, trg, err, term, chip_header_en,
                matching_mode_flag, buf_words >= FULL_LEVEL, buf_words >= ALMOST_FULL_RESET, hd};
    endfunction
    // Pulses one event description and looks for the queue word one cycle later.
    task automatic ev(input logic hits, input logic push);
        event_in <= '{done: 1'b1, count: 16'h1234, words: 16'h0007, has_hits: hits};
        @(posedge clock);
        event_in.done <= 1'b0;
        @(posedge clock);
        check("queue push", {31'h0, evq_push}, {31'h0, push});
        if (push) check("queue word", evq_word, 32'h12340007);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        final_report();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        {srst, switch_term, matching_mode_flag, chip_header_en, pair_mode} = 5'h10;
        {trigger_dropped, chain_done, chip_word_valid, chip_error, resolution_code} = '0;
        {buf_words, buf_events, chip_word, event_in} = '0;
        switch_base = 8'h5A;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rd_chk("control", OFS_GENERAL_CONTROL, 32'h0020);
        rd_chk("vector", OFS_INT_VECTOR, 32'h00DD);
        rd_chk("level", OFS_INT_LEVEL, 32'h0);
        rd_chk("slot", OFS_SLOT_ID, 32'h001F);
        rd_chk("bcast", OFS_BCAST_BASE, 32'h00AA);
        rd_chk("reloc select", OFS_RELOC_SELECT, 32'h0);
        rd_chk("unmapped", 16'h1100, 32'h0);
        rd_chk("empty no berr", 16'h0000, 32'h0);
        for (int i = 0; i < 5; i++) begin
            buf_words <= lv[i];
            buf_events <= 16'(i);
            matching_mode_flag <= i[0];
            chip_header_en <= i[1];
            pair_mode <= i[2];
            resolution_code <= 2'(i % 3);
            @(posedge clock);
            rd_chk("status", OFS_MODULE_STATUS, stat(0, 0, 0, 4'h0));
        end
        {buf_words, buf_events} <= '0;
        wr(OFS_GENERAL_CONTROL, 32'h03BE);
        rd_chk("control rw", OFS_GENERAL_CONTROL, 32'h03BE);
        ev(1'b1, 1'b1);
        ev(1'b0, 1'b1);
        trigger_dropped <= 1'b1;
        chip_error <= 4'h5;
        @(posedge clock);
        {trigger_dropped, chip_error} <= '0;
        wr(OFS_MODULE_STATUS, 32'hFFFF);
        rd_chk("status flags", OFS_MODULE_STATUS, stat(1, 0, 1, 4'h5));
        rd_chk("status cleared", OFS_MODULE_STATUS, stat(0, 0, 1, 4'h5));
        wr(OFS_GENERAL_CONTROL, 32'h0100);
        switch_term <= 1'b1;
        ev(1'b0, 1'b0);
        wr(OFS_GENERAL_CONTROL, 32'h0041);
        chip_word_valid <= 1'b1;
        @(posedge clock);
        chip_word_valid <= 1'b0;
        @(posedge clock);
        check("chip word blocked", {31'h0, buf_word_valid}, 32'h0);
        wr(OFS_TEST_WORD, 32'hA5C30F96);
        m.xfer(1'b0, 16'h0000, 32'h0, 1'b0, rd, resp);
        check("empty read", {30'h0, resp}, 32'h1);
        rd_chk("berr seen", OFS_MODULE_STATUS, stat(0, 1, 1, 4'h5));
        rd_chk("berr cleared", OFS_MODULE_STATUS, stat(0, 0, 1, 4'h5));
        wr(OFS_ALMOST_FULL, 32'h0005);
        buf_words <= 16'h0005;
        chain_done <= 1'b1;
        m.mode(1'b1, 1'b1);
        m.xfer(1'b0, 16'h0000, 32'h0, 1'b0, rd, resp);
        check("block end", {30'h0, resp}, 32'h1);
        m.mode(1'b0, 1'b1);
        m.xfer(1'b0, OFS_MODULE_STATUS, 32'h0, 1'b0, rd, resp);
        check("drained in chain", {31'h0, rd[ST_DRAINED]}, 32'h1);
        check("berr seen block", {31'h0, rd[ST_BERR_SEEN]}, 32'h1);
        check("almost full level", {31'h0, rd[ST_ALMOST_FULL]}, 32'h1);
        m.mode(1'b0, 1'b0);
        {buf_words, chain_done} <= '0;
        wr(OFS_RELOC_HIGH, 32'h0012);
        wr(OFS_RELOC_MID, 32'h0034);
        rd_chk("reloc high", OFS_RELOC_HIGH, 32'h0012);
        check("switch base", {16'h0, active_base}, {24'h0, switch_base});
        wr(OFS_SLOT_ID, 32'h000A);
        wr(OFS_RELOC_SELECT, 32'h0001);
        @(posedge clock);
        check("reloc base", {16'h0, active_base}, 32'h1234);
        check("slot", {27'h0, slot_identifier}, 32'h0A);
        wr(OFS_INT_LEVEL, 32'hFFF5);
        @(posedge clock);
        check("irq level", {29'h0, irq_level}, 32'h5);
        wr(OFS_INT_VECTOR, 32'h0042);
        m.xfer(1'b0, 16'h0, 32'h0, 1'b1, rd, resp);
        check("vector answer", rd, 32'h42);
        wr(OFS_BCAST_BASE, 32'h0033);
        rd_chk("bcast rw", OFS_BCAST_BASE, 32'h0033);
        wr(OFS_CHAIN_CTRL, 32'h0003);
        rd_chk("chain ctrl", OFS_CHAIN_CTRL, 32'h0003);
        check("bcast out", {24'h0, bcast_base}, 32'h33);
        check("chain out", {16'h0, chain_ctrl}, 32'h0003);
        wr(OFS_MODULE_RESET, 32'h0);
        check("reset pulse", {31'h0, module_reset_pulse}, 32'h1);
        @(posedge clock);
        check("reset pulse end", {31'h0, module_reset_pulse}, 32'h0);
        @(posedge clock);
        final_report();
    end
endmodule
